// ===== src/brc_config_regs.sv
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
//
// Overview of operation
// - auto random enable set: generate randoms from seed, load as CSMA-CA backoff period.
// - three-bit rate code picks unit 1/320/100/50/20/10/6.667/5 us.
// - the selected rate unit clocks the timer source and backoff counting.
// - extended enable set: rate comes from the 16-bit divisor, not the code.
// - extended rate equals (48 MHz / 2) divided by the divisor value.
// - extended divisor resets to 00f0, a divisor of 240.
// - zero minimum exponent allowed; nonzero needed for CSMA-CA to reach CCA.
// - minimum backoff exponent register resets to 03.
// - writing 1 to calibration launch starts calibration; writing 0 does nothing.
//
module brc_config_regs #(
  parameter int ADDR_W = 12,
  parameter int CYC_320US = brc_pkg::BRC_CYC_320US,
  parameter int CYC_100US = brc_pkg::BRC_CYC_100US,
  parameter int CYC_50US = brc_pkg::BRC_CYC_50US
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] max_backoff_exponent_field,
  input wire logic backoff_request,
  output logic backoff_period_load,
  output logic [15:0] backoff_period_value,
  output logic rate_tick,
  output logic [3:0] min_backoff_exponent_field,
  output logic cca_permitted,
  output logic calibration_launch,
  input wire logic calibration_done
);

  import brc_pkg::*;

  // refuse sizes that the decode or the divider accumulator cannot hold
  if (ADDR_W < 10) begin : g_bad_addr_w
    $error("brc_config_regs: address too narrow for the register indices");
  end
  if (CYC_320US < 1 || CYC_100US < 1 || CYC_50US < 1) begin : g_bad_counts
    $error("brc_config_regs: timing counts must be positive");
  end
  if (CYC_320US * BRC_ACC_STEP >= 2 ** BRC_ACC_W) begin : g_bad_range
    $error("brc_config_regs: timing count too large for the divider");
  end

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // one aligned word per register index
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    hit = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
  endfunction

  logic [7:0] backoff_random_ctrl;
  logic [7:0] timing_rate_select;
  logic [15:0] extended_rate_divisor;
  logic [15:0] backoff_seed;
  logic [7:0] min_backoff_exponent;
  logic cal_active;
  logic [15:0] lfsr;
  logic auto_en_q;

  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hit_ctrl = hit(paddr, BRC_IDX_BACKOFF_CTRL);
  wire hit_rate = hit(paddr, BRC_IDX_RATE_SELECT);
  wire hit_ext_lo = hit(paddr, BRC_IDX_EXT_DIV_LO);
  wire hit_ext_hi = hit(paddr, BRC_IDX_EXT_DIV_HI);
  wire hit_seed = hit(paddr, BRC_IDX_SEED);
  wire hit_status = hit(paddr, BRC_IDX_STATUS);
  wire hit_min_be = hit(paddr, BRC_IDX_MIN_BE);
  wire hit_cal = hit(paddr, BRC_IDX_CAL_CTRL);
  wire mapped = hit_ctrl || hit_rate || hit_ext_lo || hit_ext_hi || hit_seed ||
                hit_status || hit_min_be || hit_cal;
  wire status_write = hit_status && pwrite;
  wire wr = access && pwrite && mapped && !status_write;
  wire wr_b0 = wr && pstrb[0];
  wire wr_b1 = wr && pstrb[1];

  // zero-wait slave; unmapped or status write answers with error
  assign pready = 1'b1;
  assign pslverr = access && (!mapped || status_write);

  // ****************************************************************
  // register writes
  // ****************************************************************
  wire wr_ctrl = wr_b0 && hit_ctrl;
  wire wr_rate = wr_b0 && hit_rate;
  wire wr_ext_lo = wr_b0 && hit_ext_lo;
  wire wr_ext_hi = wr_b0 && hit_ext_hi;
  wire wr_min_be = wr_b0 && hit_min_be;
  wire wr_cal = wr_b0 && hit_cal;
  wire launch = wr_cal && pwdata[BRC_FLD_CAL_LAUNCH];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      backoff_random_ctrl <= BRC_RST_BACKOFF_CTRL;
      timing_rate_select <= BRC_RST_RATE_SELECT;
      min_backoff_exponent <= BRC_RST_MIN_BE;
    end else begin
      if (wr_ctrl) begin
        backoff_random_ctrl <= {7'h00, pwdata[BRC_FLD_AUTO_EN]};
      end
      if (wr_rate) begin
        timing_rate_select <= {4'h0, pwdata[3:0]};
      end
      if (wr_min_be) begin
        min_backoff_exponent <= {4'h0, pwdata[3:0]};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      extended_rate_divisor <= BRC_RST_EXT_DIV;
    end else begin
      if (wr_ext_lo) begin
        extended_rate_divisor[7:0] <= pwdata[7:0];
      end
      if (wr_ext_hi) begin
        extended_rate_divisor[15:8] <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      backoff_seed <= BRC_RST_SEED;
    end else begin
      if (wr_b0 && hit_seed) begin
        backoff_seed[7:0] <= pwdata[7:0];
      end
      if (wr_b1 && hit_seed) begin
        backoff_seed[15:8] <= pwdata[15:8];
      end
    end
  end

  // ****************************************************************
  // calibration launch
  // ****************************************************************
  // a write of 0 leaves everything untouched; launch wins over done
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      calibration_launch <= 1'b0;
      cal_active <= BRC_RST_CAL_CTRL[BRC_FLD_CAL_LAUNCH];
    end else begin
      calibration_launch <= launch;
      if (launch) begin
        cal_active <= 1'b1;
      end else if (calibration_done) begin
        cal_active <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // timing rate unit
  // ****************************************************************
  logic [BRC_ACC_W-1:0] code_threshold;
  logic [BRC_ACC_W-1:0] ext_threshold;
  logic [BRC_ACC_W-1:0] rate_threshold;
  wire ext_en = timing_rate_select[BRC_FLD_EXT_EN];
  wire [BRC_RATE_CODE_W-1:0] rate_code =
    timing_rate_select[BRC_FLD_RATE_CODE +: BRC_RATE_CODE_W];

  // each threshold is the tick period in clocks times the step
  always_comb begin
    case (rate_code)
      3'h0: code_threshold = BRC_ACC_W'(BRC_CYC_1US * BRC_ACC_STEP);
      3'h1: code_threshold = BRC_ACC_W'(CYC_320US * BRC_ACC_STEP);
      3'h2: code_threshold = BRC_ACC_W'(CYC_100US * BRC_ACC_STEP);
      3'h3: code_threshold = BRC_ACC_W'(CYC_50US * BRC_ACC_STEP);
      3'h4: code_threshold = BRC_ACC_W'(BRC_CYC_20US * BRC_ACC_STEP);
      3'h5: code_threshold = BRC_ACC_W'(BRC_CYC_10US * BRC_ACC_STEP);
      3'h6: code_threshold = BRC_ACC_W'(BRC_CYC_6667NS * BRC_ACC_STEP);
      3'h7: code_threshold = BRC_ACC_W'(BRC_CYC_5US * BRC_ACC_STEP);
      default: code_threshold = BRC_ACC_W'(BRC_CYC_1US * BRC_ACC_STEP);
    endcase
  end

  // divisor * 400 clocks per 48 steps gives (48 MHz / 2) / divisor
  assign ext_threshold = BRC_ACC_W'(extended_rate_divisor) *
                         BRC_ACC_W'(BRC_EXT_SCALE);
  assign rate_threshold = ext_en ? ext_threshold : code_threshold;

  wire rate_restart = wr_rate || wr_ext_lo || wr_ext_hi;

  brc_rate_tick #(
    .ACC_W(BRC_ACC_W),
    .STEP(BRC_ACC_STEP)
  ) u_rate_tick (
    .ref_clk(ref_clk),
    .rst(rst),
    .restart(rate_restart),
    .threshold(rate_threshold),
    .tick(rate_tick)
  );

  // ****************************************************************
  // automatic random backoff
  // ****************************************************************
  wire auto_en = backoff_random_ctrl[BRC_FLD_AUTO_EN];
  wire [15:0] seed_nonzero = (backoff_seed == 16'h0000) ? 16'h0001 : backoff_seed;
  wire [15:0] lfsr_step = {1'b0, lfsr[15:1]} ^ (lfsr[0] ? BRC_LFSR_TAPS : 16'h0000);

  // seed reloads while disabled and at the enable edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lfsr <= 16'h0001;
      auto_en_q <= 1'b0;
    end else begin
      auto_en_q <= auto_en;
      if (!auto_en || !auto_en_q) begin
        lfsr <= seed_nonzero;
      end else if (backoff_request || rate_tick) begin
        lfsr <= lfsr_step;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      backoff_period_load <= 1'b0;
      backoff_period_value <= 16'h0000;
    end else begin
      backoff_period_load <= auto_en && auto_en_q && backoff_request;
      if (auto_en && auto_en_q && backoff_request) begin
        backoff_period_value <= lfsr;
      end
    end
  end

  // ****************************************************************
  // backoff exponent
  // ****************************************************************
  assign min_backoff_exponent_field = min_backoff_exponent[BRC_FLD_MIN_BE +: BRC_MIN_BE_W];
  // order error is reported in status only; the exponent is never clamped
  wire order_error = min_backoff_exponent_field >= max_backoff_exponent_field;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cca_permitted <= 1'b1;
    end else begin
      cca_permitted <= min_backoff_exponent_field != 4'h0;
    end
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_mux = {24'h00_0000, backoff_random_ctrl};
    end else if (hit_rate) begin
      rd_mux = {24'h00_0000, timing_rate_select};
    end else if (hit_ext_lo) begin
      rd_mux = {24'h00_0000, extended_rate_divisor[7:0]};
    end else if (hit_ext_hi) begin
      rd_mux = {24'h00_0000, extended_rate_divisor[15:8]};
    end else if (hit_seed) begin
      rd_mux = {16'h0000, backoff_seed};
    end else if (hit_min_be) begin
      rd_mux = {24'h00_0000, min_backoff_exponent};
    end else if (hit_cal) begin
      rd_mux = {31'h0000_0000, cal_active};
    end else if (hit_status) begin
      rd_mux[BRC_FLD_STAT_ORDER_ERR] = order_error;
      rd_mux[BRC_FLD_STAT_CCA_OK] = cca_permitted;
      rd_mux[BRC_FLD_STAT_RAND +: 16] = lfsr;
    end
  end

  // captured in setup so the access phase sees stable flop data
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule // brc_config_regs

// ===== src/brc_pkg.sv
package brc_pkg;

  // ****************************************************************
  // register indices (byte address = index * 4)
  // ****************************************************************
  localparam logic [7:0] BRC_IDX_BACKOFF_CTRL = 8'h35;
  localparam logic [7:0] BRC_IDX_RATE_SELECT = 8'h36;
  localparam logic [7:0] BRC_IDX_EXT_DIV_LO = 8'h38;
  localparam logic [7:0] BRC_IDX_EXT_DIV_HI = 8'h39;
  localparam logic [7:0] BRC_IDX_SEED = 8'h3a;
  localparam logic [7:0] BRC_IDX_STATUS = 8'h3c;
  localparam logic [7:0] BRC_IDX_MIN_BE = 8'h3e;
  localparam logic [7:0] BRC_IDX_CAL_CTRL = 8'h3f;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] BRC_RST_BACKOFF_CTRL = 8'h00;
  localparam logic [7:0] BRC_RST_RATE_SELECT = 8'h00;
  localparam logic [15:0] BRC_RST_EXT_DIV = 16'h00f0;
  localparam logic [15:0] BRC_RST_SEED = 16'h0000;
  localparam logic [7:0] BRC_RST_MIN_BE = 8'h03;
  localparam logic [7:0] BRC_RST_CAL_CTRL = 8'h00;

  // ****************************************************************
  // field positions and widths
  // ****************************************************************
  localparam int BRC_FLD_AUTO_EN = 0;
  localparam int BRC_FLD_RATE_CODE = 0;
  localparam int BRC_RATE_CODE_W = 3;
  localparam int BRC_FLD_EXT_EN = 3;
  localparam int BRC_FLD_MIN_BE = 0;
  localparam int BRC_MIN_BE_W = 4;
  localparam int BRC_FLD_CAL_LAUNCH = 0;
  localparam int BRC_FLD_STAT_ORDER_ERR = 0;
  localparam int BRC_FLD_STAT_CCA_OK = 1;
  localparam int BRC_FLD_STAT_RAND = 16;
  localparam logic [15:0] BRC_LFSR_TAPS = 16'hb400;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int BRC_CLK_PERIOD_PS = 5000;
  localparam int BRC_CLK_MHZ = 200;
  localparam int BRC_T_1US_PS = 1000000;
  localparam int BRC_T_320US_PS = 320000000;
  localparam int BRC_T_100US_PS = 100000000;
  localparam int BRC_T_50US_PS = 50000000;
  localparam int BRC_T_20US_PS = 20000000;
  localparam int BRC_T_10US_PS = 10000000;
  localparam int BRC_T_6667NS_PS = 6667000;
  localparam int BRC_T_5US_PS = 5000000;
  localparam int BRC_CYC_1US = BRC_T_1US_PS / BRC_CLK_PERIOD_PS;
  localparam int BRC_CYC_320US = BRC_T_320US_PS / BRC_CLK_PERIOD_PS;
  localparam int BRC_CYC_100US = BRC_T_100US_PS / BRC_CLK_PERIOD_PS;
  localparam int BRC_CYC_50US = BRC_T_50US_PS / BRC_CLK_PERIOD_PS;
  localparam int BRC_CYC_20US = BRC_T_20US_PS / BRC_CLK_PERIOD_PS;
  localparam int BRC_CYC_10US = BRC_T_10US_PS / BRC_CLK_PERIOD_PS;
  localparam int BRC_CYC_6667NS = BRC_T_6667NS_PS / BRC_CLK_PERIOD_PS;
  localparam int BRC_CYC_5US = BRC_T_5US_PS / BRC_CLK_PERIOD_PS;
  // extended rate: tick period = div * (clk_mhz * ref_div) / ref_mhz clocks
  localparam int BRC_REF_MHZ = 48;
  localparam int BRC_REF_DIV = 2;
  localparam int BRC_ACC_STEP = BRC_REF_MHZ;
  localparam int BRC_EXT_SCALE = BRC_CLK_MHZ * BRC_REF_DIV;
  localparam int BRC_ACC_W = 26;

endpackage

// ===== src/brc_rate_tick.sv
`timescale 1ns/1ps
// ******************************************************************
// fractional divider: one-cycle tick each threshold/step clocks
// ******************************************************************
module brc_rate_tick #(
  parameter int ACC_W = 26,
  parameter int STEP = 48
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic [ACC_W-1:0] threshold,
  output logic tick
);

  localparam logic [ACC_W-1:0] STEP_W = ACC_W'(STEP);

  logic [ACC_W-1:0] acc;
  logic [ACC_W:0] next_acc_sum;
  logic [ACC_W-1:0] eff_threshold;
  logic wrap;

  if (ACC_W < 8 || STEP < 1) begin : g_bad_params
    $error("brc_rate_tick: unsupported parameters");
  end

  // threshold below one step would tick every cycle anyway
  assign eff_threshold = (threshold < STEP_W) ? STEP_W : threshold;
  assign next_acc_sum = {1'b0, acc} + {1'b0, STEP_W};
  assign wrap = next_acc_sum >= {1'b0, eff_threshold};

  always_ff @(posedge ref_clk) begin
    if (rst || restart) begin
      acc <= '0;
      tick <= 1'b0;
    end else begin
      acc <= wrap ? ACC_W'(next_acc_sum - {1'b0, eff_threshold}) : next_acc_sum[ACC_W-1:0];
      tick <= wrap;
    end
  end

endmodule // brc_rate_tick

// ===== sim/brc_config_regs_checker.sv
`timescale 1ns/1ps
module brc_config_regs_checker #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] max_backoff_exponent_field,
  input wire logic backoff_request,
  input wire logic backoff_period_load,
  input wire logic [15:0] backoff_period_value,
  input wire logic rate_tick,
  input wire logic [3:0] min_backoff_exponent_field,
  input wire logic cca_permitted,
  input wire logic calibration_launch,
  input wire logic calibration_done
);
  import brc_pkg::*;
  // ********
  // write decode and enable tracking
  // ********
  logic wr, wr_cal, wr_min, wr_ctl, en_q, en_d1, en_d2;
  logic [ADDR_W-3:0] idx;
  assign idx = paddr[ADDR_W-1:2];
  assign wr = psel & penable & pwrite & pready & ~pslverr & pstrb[0] & (paddr[1:0] == 2'b00);
  assign wr_cal = wr & (idx == (ADDR_W-2)'(BRC_IDX_CAL_CTRL));
  assign wr_min = wr & (idx == (ADDR_W-2)'(BRC_IDX_MIN_BE));
  assign wr_ctl = wr & (idx == (ADDR_W-2)'(BRC_IDX_BACKOFF_CTRL));
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      en_q <= 1'b0;
    end else if (wr_ctl) begin
      en_q <= pwdata[0];
    end
    en_d1 <= en_q & ~rst;
    en_d2 <= en_d1 & ~rst;
  end
  // ********
  // properties
  // ********
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_launch_pulse: assert property (wr_cal && pwdata[0] |=> calibration_launch)
    else $error("no launch pulse after calibration write of one");
  a_launch_cause: assert property (calibration_launch |-> $past(wr_cal && pwdata[0]))
    else $error("launch pulse without calibration write");
  a_cal_zero_quiet: assert property (wr_cal && !pwdata[0] |=> !calibration_launch)
    else $error("launch pulse after calibration write of zero");
  a_cca_gate: assert property (!$past(rst) |-> cca_permitted == ($past(min_backoff_exponent_field) != 4'h0))
    else $error("cca gate does not follow minimum exponent");
  a_reset_min: assert property ($past(rst) |-> min_backoff_exponent_field == 4'h3)
    else $error("minimum exponent not three after reset");
  a_min_write: assert property (wr_min |=> min_backoff_exponent_field == $past(pwdata[3:0]))
    else $error("minimum exponent not taken from write");
  a_load_nonzero: assert property (backoff_period_load |-> backoff_period_value != 16'h0000)
    else $error("random backoff value is zero");
  a_load_needs_en: assert property (backoff_period_load |-> $past(backoff_request) && (en_q || en_d1 || en_d2))
    else $error("backoff load without request or enable");
  a_load_follows: assert property (backoff_request && en_q && en_d1 && en_d2 |=> backoff_period_load)
    else $error("backoff request not answered by load");
endmodule // brc_config_regs_checker

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  import brc_pkg::*;
  logic ref_clk, rst, psel, penable, pwrite, req, cal_done, pready, err_o, err, ld, tick, launch, cca;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, max_be, min_be;
  logic [15:0] val;
  int fail_count, n_tests, n_launch, n_load, gap, n0;
  logic [7:0] idx_t[6] = '{BRC_IDX_BACKOFF_CTRL, BRC_IDX_RATE_SELECT, BRC_IDX_EXT_DIV_LO,
    BRC_IDX_EXT_DIV_HI, BRC_IDX_MIN_BE, BRC_IDX_CAL_CTRL};
  logic [31:0] rst_t[6] = '{32'h0, 32'h0, 32'hf0, 32'h0, 32'h3, 32'h0};
  int per[8] = '{200, 320, 100, 50, 4000, 2000, 1333, 1000};
  brc_config_regs #(.ADDR_W(12), .CYC_320US(320), .CYC_100US(100), .CYC_50US(50)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(err_o), .max_backoff_exponent_field(max_be), .backoff_request(req),
    .backoff_period_load(ld), .backoff_period_value(val), .rate_tick(tick),
    .min_backoff_exponent_field(min_be), .cca_permitted(cca), .calibration_launch(launch),
    .calibration_done(cal_done));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (launch === 1'b1) n_launch++;
    if (ld === 1'b1) n_load++;
  end
  // ********
  // tasks
  // ********
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = prdata;
    err = err_o;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic next_tick(output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      c++;
    end while (tick !== 1'b1 && c < 70000);
  endtask
  task automatic pulse_req;
    req <= 1'b1;
    @(posedge ref_clk);
    req <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    fail_count++;
    results();
  end
  // ********
  // main sequence
  // ********
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, req, cal_done} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    max_be = 4'h8;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    chk("min field", min_be, 4'h3);
    chk("cca gate", cca, 1);
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, idx_t[i], 32'h0);
      chk("reset value", rd, rst_t[i]);
    end
    xfer(1'b0, 8'h37, 32'h0);
    chk("unmapped error", err, 1);
    for (int c = 0; c < 8; c++) begin
      xfer(1'b1, BRC_IDX_RATE_SELECT, c);
      next_tick(gap);
      next_tick(gap);
      chk("tick gap", gap, per[c]);
    end
    xfer(1'b1, BRC_IDX_RATE_SELECT, 32'h8);
    next_tick(gap);
    next_tick(gap);
    chk("ext gap reset div", gap, 2000);
    xfer(1'b1, BRC_IDX_EXT_DIV_LO, 32'h18);
    xfer(1'b1, BRC_IDX_EXT_DIV_HI, 32'h0);
    next_tick(gap);
    next_tick(gap);
    chk("ext gap div 24", gap, 200);
    xfer(1'b1, BRC_IDX_EXT_DIV_LO, 32'h34);
    xfer(1'b1, BRC_IDX_EXT_DIV_HI, 32'h12);
    xfer(1'b0, BRC_IDX_EXT_DIV_LO, 32'h0);
    chk("div low byte", rd, 32'h34);
    xfer(1'b0, BRC_IDX_EXT_DIV_HI, 32'h0);
    chk("div high byte", rd, 32'h12);
    xfer(1'b1, BRC_IDX_MIN_BE, 32'h0);
    @(posedge ref_clk);
    chk("cca at zero", cca, 0);
    chk("min zero", min_be, 4'h0);
    xfer(1'b1, BRC_IDX_MIN_BE, 32'h5);
    @(posedge ref_clk);
    chk("cca at five", cca, 1);
    xfer(1'b0, BRC_IDX_MIN_BE, 32'h0);
    chk("min readback", rd, 32'h5);
    xfer(1'b0, BRC_IDX_STATUS, 32'h0);
    chk("status order ok", rd, 32'h0001_0002);
    max_be <= 4'h5;
    xfer(1'b0, BRC_IDX_STATUS, 32'h0);
    chk("status order error", rd, 32'h0001_0003);
    n0 = n_launch;
    xfer(1'b1, BRC_IDX_CAL_CTRL, 32'h0);
    repeat (3) @(posedge ref_clk);
    chk("launch on zero", n_launch - n0, 0);
    xfer(1'b1, BRC_IDX_CAL_CTRL, 32'h1);
    repeat (3) @(posedge ref_clk);
    chk("launch on one", n_launch - n0, 1);
    xfer(1'b0, BRC_IDX_CAL_CTRL, 32'h0);
    chk("cal busy", rd, 32'h1);
    cal_done <= 1'b1;
    @(posedge ref_clk);
    cal_done <= 1'b0;
    xfer(1'b0, BRC_IDX_CAL_CTRL, 32'h0);
    chk("cal idle", rd, 32'h0);
    n0 = n_load;
    pulse_req();
    chk("load disabled", n_load - n0, 0);
    xfer(1'b1, BRC_IDX_SEED, 32'hace1);
    xfer(1'b1, BRC_IDX_BACKOFF_CTRL, 32'h1);
    repeat (4) @(posedge ref_clk);
    pulse_req();
    chk("load enabled", n_load - n0, 1);
    chk("value nonzero", val !== 16'h0, 1);
    chk("value seeded", val, 16'hace1);
    results();
  end
endmodule // testbench
bind brc_config_regs brc_config_regs_checker #(.ADDR_W(ADDR_W)) chk_u (
  .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .max_backoff_exponent_field(max_backoff_exponent_field),
  .backoff_request(backoff_request), .backoff_period_load(backoff_period_load),
  .backoff_period_value(backoff_period_value), .rate_tick(rate_tick),
  .min_backoff_exponent_field(min_backoff_exponent_field), .cca_permitted(cca_permitted),
  .calibration_launch(calibration_launch), .calibration_done(calibration_done));
